// >>> rtl/flag_unit.v
// alu flag generation for add, subtract, logic and rotate through carry
`timescale 1ns/1ps
`include "sfr_core_map.vh"
module flag_unit (
  input wire [2:0] op,           // operation class
  input wire [7:0] a,            // first operand
  input wire [7:0] b,            // second operand / logic result
  input wire carry_in,           // current ripple-out flag
  output reg [7:0] result,       // operation result
  output reg carry_out,          // new ripple-out flag
  output reg half_out,           // new half-ripple flag
  output reg wrap_out,           // new signed-wrap flag
  output reg updates_arith       // operation touches ac/ov (add, subtract)
);
  reg [8:0] sum;
  reg [4:0] low;
  reg [7:0] nb;
  reg c7;
  always @* begin
    sum = 9'h000;
    low = 5'h00;
    nb = ~b;
    c7 = 1'b0;
    result = b;
    carry_out = carry_in;
    half_out = 1'b0;
    wrap_out = 1'b0;
    updates_arith = 1'b0;
    case (op)
      `OP_ADD: begin
        sum = {1'b0, a} + {1'b0, b};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        c7 = a[7] ^ b[7] ^ sum[7];
        result = sum[7:0];
        carry_out = sum[8];
        half_out = low[4];
        wrap_out = c7 ^ sum[8];
        updates_arith = 1'b1;
      end
      `OP_SUB: begin
        // a - b as a + ~b + 1: carry set means no borrow
        sum = {1'b0, a} + {1'b0, nb} + 9'h001;
        low = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + 5'h01;
        c7 = a[7] ^ nb[7] ^ sum[7];
        result = sum[7:0];
        carry_out = sum[8];
        half_out = low[4];
        wrap_out = c7 ^ sum[8];
        updates_arith = 1'b1;
      end
      `OP_RLC: begin
        result = {a[6:0], carry_in};
        carry_out = a[7];
      end
      `OP_RRC: begin
        result = {carry_in, a[7:1]};
        carry_out = a[0];
      end
      default: begin
        result = b;
      end
    endcase
  end
endmodule // flag_unit

// >>> rtl/sfr_core_map.vh
// address map, field positions and reset values for the sfr core
`ifndef SFR_CORE_MAP_VH
`define SFR_CORE_MAP_VH
`define A_IND0 8'h00
`define A_PTR0 8'h01
`define A_IND1 8'h02
`define A_PTR1 8'h03
`define A_BANK 8'h04
`define A_WORK 8'h05
`define A_PCLO 8'h06
`define A_TABLE_POINTER 8'h07
`define A_TABLE_HIGH_BYTE 8'h08
`define A_STAT 8'h0a
`define SFR_LAST 8'h3f
`define UNUSED_FIRST 8'h3a
`define GP_FIRST 8'h40
`define ST_C 0
`define ST_AC 1
`define ST_Z 2
`define ST_OV 3
`define ST_PDF 4
`define ST_TO 5
`define RST_BYTE 8'h00
`define RST_BANK 1'b0
`define OP_ADD 3'h1
`define OP_SUB 3'h2
`define OP_LOGIC 3'h3
`define OP_RLC 3'h4
`define OP_RRC 3'h5
`define OP_MOVE 3'h0
`endif

// >>> rtl/sfr_indirect_bank_status.v
// special function registers: indirect ports, pointers, bank, work, status
//
// Contract
// - unused locations 3ah..3fh read zero
// - indirect ports redirect to pointer target
// - port 0 bank 0 only, port 1 banked
// - indirect to a port reads zero, ignores writes
// - pointers are ordinary read/write registers
// - bank select value picks data bank
// - resets clear bank, except sleeping watchdog reset
// - special area identical in every bank
// - direct addressing always reaches bank 0
// - alu results land in work register (with alu_to_mem the core writes them to addr instead)
// - low pc write jumps in page, dummy cycle
// - table read: high byte to table_high_byte
// - status writes never touch sleep, watchdog flags
// - ripple-out on carry, no borrow, rotate
// - half-ripple on low nibble carry, no borrow
// - nil-result set when result is zero
// - signed-wrap on carry in/out mismatch
// - sleep flag: clear power-up/wdt clear, set halt
// - watchdog flag: set only by time-out
// - no automatic status save on call/interrupt
// - single bank: general memory 40h..ffh
`timescale 1ns/1ps
`include "sfr_core_map.vh"
module sfr_indirect_bank_status #(
  parameter BANK_W = 1,          // bank select width (1: two banks)
  parameter NUM_BANKS = 2        // banks of general memory present
) (
  input wire core_clk,           // system clock
  input wire rst,                // reset, active high; asynchronous except bank select, which samples it on the clock
  input wire power_up,           // reset cause: power-up
  input wire wdt_reset_asleep,   // reset cause: watchdog in power-down
  input wire rd_en,              // data memory read request
  input wire wr_en,              // data memory write request
  input wire [7:0] addr,         // direct address
  input wire [7:0] wr_data,      // write data
  input wire alu_en,             // alu operation to work register
  input wire alu_to_mem,         // alu result written to addr instead of work register
  input wire [2:0] alu_op,       // alu operation class
  input wire [7:0] alu_b,        // alu second operand or logic result
  input wire logic_op,           // hold half-ripple and signed-wrap flags
  input wire work_load,          // load work register from wr_data
  input wire table_rd,           // table read done, data on tbl_data
  input wire [15:0] tbl_data,    // program word fetched at table pointer
  input wire wdt_clear,          // watchdog clear instruction
  input wire halt,               // halt instruction
  input wire wdt_timeout,        // watchdog time-out event
  input wire [7:0] ext_rd_data,  // read data from other sfr blocks
  output reg [7:0] rd_data,      // read data
  output reg rd_valid,           // rd_data valid pulse
  output reg [7:0] work_out,     // work register
  output reg [7:0] pc_low,       // program counter low byte
  output reg pc_load,            // jump pulse after low byte write
  output reg stall,              // dummy cycle after jump
  output reg [7:0] table_addr,   // table pointer to program memory
  output reg [7:0] status_out    // status flags
);
  localparam DEPTH = NUM_BANKS * 192;
  reg [7:0] gp_mem [0:DEPTH-1];
  reg [7:0] ptr0_r, ptr1_r, table_high_byte_r;
  reg [BANK_W-1:0] bank_r;
  reg c_r, ac_r, z_r, ov_r, pdf_r, to_r;
  reg [7:0] eff_addr;
  reg [BANK_W-1:0] eff_bank;
  reg indir_self;
  reg [7:0] rd_nxt;
  wire [7:0] fu_res;
  wire fu_c, fu_ac, fu_ov, fu_arith;
  wire [7:0] st_now = {2'b00, to_r, pdf_r, ov_r, z_r, ac_r, c_r};
  integer i;

  function is_port;
    input [7:0] a;
    begin
      is_port = (a == `A_IND0) || (a == `A_IND1);
    end
  endfunction

  function [8:0] gp_index;
    input [BANK_W-1:0] bk;
    input [7:0] a;
    begin
      gp_index = bk * 9'd192 + {1'b0, a} - {1'b0, `GP_FIRST};
    end
  endfunction

  flag_unit u_flag (
    .op(alu_op),
    .a(work_out),
    .b(alu_b),
    .carry_in(c_r),
    .result(fu_res),
    .carry_out(fu_c),
    .half_out(fu_ac),
    .wrap_out(fu_ov),
    .updates_arith(fu_arith)
  );

  // address resolution
  always @* begin
    eff_addr = addr;
    eff_bank = {BANK_W{1'b0}};
    indir_self = 1'b0;
    if (addr == `A_IND0) begin
      eff_addr = ptr0_r;
    end else if (addr == `A_IND1) begin
      eff_addr = ptr1_r;
      eff_bank = bank_r;
    end
    if (is_port(addr) && is_port(eff_addr))
      indir_self = 1'b1;
  end

  // read mux; special area ignores bank
  always @* begin
    rd_nxt = `RST_BYTE;
    if (indir_self) begin
      rd_nxt = `RST_BYTE;
    end else if (eff_addr >= `GP_FIRST) begin
      if (eff_bank < NUM_BANKS)
        rd_nxt = gp_mem[gp_index(eff_bank, eff_addr)];
    end else begin
      case (eff_addr)
        `A_PTR0: rd_nxt = ptr0_r;
        `A_PTR1: rd_nxt = ptr1_r;
        `A_BANK: rd_nxt = {{(8-BANK_W){1'b0}}, bank_r};
        `A_WORK: rd_nxt = work_out;
        `A_PCLO: rd_nxt = pc_low;
        `A_TABLE_POINTER: rd_nxt = table_addr;
        `A_TABLE_HIGH_BYTE: rd_nxt = table_high_byte_r;
        `A_STAT: rd_nxt = st_now;
        // reserved gap below general memory reads zero here
        default: rd_nxt = (eff_addr >= `UNUSED_FIRST) ? `RST_BYTE :
                          ext_rd_data;
      endcase
    end
  end

  wire do_wr = (wr_en || (alu_en && alu_to_mem)) && !indir_self;
  wire [7:0] wval = (alu_en && alu_to_mem) ? fu_res : wr_data;
  wire st_wr = do_wr && eff_addr == `A_STAT;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ptr0_r <= `RST_BYTE;
      ptr1_r <= `RST_BYTE;
      table_high_byte_r <= `RST_BYTE;
      work_out <= `RST_BYTE;
      pc_low <= `RST_BYTE;
      pc_load <= 1'b0;
      stall <= 1'b0;
      table_addr <= `RST_BYTE;
      rd_data <= `RST_BYTE;
      rd_valid <= 1'b0;
      c_r <= 1'b0;
      ac_r <= 1'b0;
      z_r <= 1'b0;
      ov_r <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      rd_data <= rd_en ? rd_nxt : `RST_BYTE;
      pc_load <= 1'b0;
      stall <= pc_load;
      if (do_wr && eff_addr < `GP_FIRST) begin
        case (eff_addr)
          `A_PTR0: ptr0_r <= wval;
          `A_PTR1: ptr1_r <= wval;
          `A_WORK: work_out <= wval;
          `A_PCLO: begin
            pc_low <= wval;
            pc_load <= 1'b1;
          end
          `A_TABLE_POINTER: table_addr <= wval;
          `A_TABLE_HIGH_BYTE: table_high_byte_r <= wval;
          default: ;
        endcase
      end
      if (st_wr) begin
        c_r <= wval[`ST_C];
        ac_r <= wval[`ST_AC];
        z_r <= wval[`ST_Z];
        ov_r <= wval[`ST_OV];
      end
      if (work_load)
        work_out <= wr_data;
      if (alu_en) begin
        if (!alu_to_mem)
          work_out <= fu_res;
        z_r <= (fu_res == 8'h00);
        c_r <= fu_c;
        if (fu_arith && !logic_op) begin
          ac_r <= fu_ac;
          ov_r <= fu_ov;
        end
      end
      if (table_rd)
        table_high_byte_r <= tbl_data[15:8];
    end
  end

  // general memory writes; no reset on data ram
  always @(posedge core_clk) begin
    for (i = 0; i < DEPTH; i = i + 1)
      if (do_wr && eff_addr >= `GP_FIRST && eff_bank < NUM_BANKS &&
          gp_index(eff_bank, eff_addr) == i)
        gp_mem[i] <= wval;
  end

  // bank select keeps value on watchdog reset while asleep
  always @(posedge core_clk) begin
    if (rst && !wdt_reset_asleep)
      bank_r <= {BANK_W{`RST_BANK}};
    else if (!rst && do_wr && eff_addr == `A_BANK)
      bank_r <= wval[BANK_W-1:0];
  end

  // system flags; status writes cannot reach them, no auto save
  always @(posedge core_clk) begin
    if (power_up) begin
      pdf_r <= 1'b0;
      to_r <= 1'b0;
    end else begin
      if (wdt_clear)
        pdf_r <= 1'b0;
      else if (halt)
        pdf_r <= 1'b1;
      if (wdt_timeout)
        to_r <= 1'b1;
      else if (wdt_clear || halt)
        to_r <= 1'b0;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst)
      status_out <= `RST_BYTE;
    else
      status_out <= st_now;
  end
endmodule // sfr_indirect_bank_status

// >>> testbench/prog_rom_model.sv
// program memory model answering table reads from the core
`timescale 1ns/1ps
module prog_rom_model (
  input wire [7:0] table_addr, // table pointer
  output wire [15:0] tbl_data // word at that address
);
  // high byte is the inverted address so both halves are distinct
  assign tbl_data = {~table_addr, table_addr};
endmodule // prog_rom_model

// >>> testbench/sfr_checker.sv
// concurrent checks on the sfr core ports
`timescale 1ns/1ps
`include "sfr_core_map.vh"
module sfr_checker (
  input wire core_clk,
  input wire rst,
  input wire power_up,
  input wire rd_en,
  input wire wr_en,
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  input wire work_load,
  input wire alu_en,
  input wire wdt_clear,
  input wire halt,
  input wire wdt_timeout,
  input wire rd_valid,
  input wire [7:0] rd_data,
  input wire [7:0] work_out,
  input wire [7:0] pc_low,
  input wire pc_load,
  input wire stall,
  input wire [7:0] status_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire quiet = !(power_up || halt || wdt_clear || wdt_timeout);
  wire pcw = wr_en && addr == `A_PCLO;
  sequence jump_s;
    pc_load && !stall ##1 stall && !pc_load ##1 !stall;
  endsequence
  a_pcl_jump: assert property (pcw |=> jump_s)
    else $error("jump pulse sequence wrong");
  a_pcl_value: assert property (pcw |=> pc_low == $past(wr_data))
    else $error("low pc byte not loaded");
  a_read_answer: assert property (rd_en |=> rd_valid)
    else $error("read not answered");
  a_unused_zero: assert property
    (rd_en && addr > 8'h39 && addr < `GP_FIRST |=> rd_data == 8'h00)
    else $error("unused location not zero");
  a_flags_held: assert property (quiet [*2] |=> $stable(status_out[5:4]))
    else $error("sleep or watchdog flag moved");
  a_halt_sleep: assert property
    (halt && !power_up && !wdt_clear |-> ##[1:2] status_out[`ST_PDF])
    else $error("halt did not set sleep flag");
  a_timeout_flag: assert property
    (wdt_timeout && !power_up |-> ##[1:2] status_out[`ST_TO])
    else $error("timeout did not set flag");
  a_clear_flags: assert property
    (wdt_clear && !halt && !wdt_timeout |-> ##[1:2] status_out[5:4] == 2'h0)
    else $error("clear left flags set");
  a_work_load: assert property
    (work_load && !alu_en && !wr_en |=> work_out == $past(wr_data))
    else $error("work register not loaded");
  a_top_zero: assert property (status_out[7:6] == 2'h0)
    else $error("unused status bits set");
endmodule // sfr_checker
bind sfr_indirect_bank_status sfr_checker chk (.*);

// >>> testbench/sfr_indirect_bank_status_tb.sv
// self-checking bench for the sfr core
`timescale 1ns/1ps
`include "sfr_core_map.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %0t got %h want %h", $time, g, e); end end
module sfr_indirect_bank_status_tb;
  reg core_clk = '0, rst = '1, power_up = '1, wdt_reset_asleep = '0;
  reg rd_en = '0, wr_en = '0, alu_en = '0, alu_to_mem = '0, logic_op = '0;
  reg work_load = '0, table_rd = '0, wdt_clear = '0, halt = '0;
  reg wdt_timeout = '0;
  reg [7:0] addr = '0, wr_data = '0, alu_b = '0;
  // nonzero so the reserved gap must be zeroed by the core itself
  reg [7:0] ext_rd_data = 8'ha5;
  reg [2:0] alu_op = '0;
  wire [15:0] tbl_data;
  wire [7:0] rd_data, work_out, pc_low, table_addr, status_out;
  wire rd_valid, pc_load, stall;
  int miscompares = 0, cmp_count = 0;
  always #20 core_clk = ~core_clk;
  sfr_indirect_bank_status uut (.*);
  prog_rom_model rom (.*);
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task wr(input [7:0] a, d);
    @(posedge core_clk);
    wr_en <= '1;
    addr <= a;
    wr_data <= d;
    @(posedge core_clk);
    wr_en <= '0;
  endtask
  task rd(input [7:0] a, e);
    @(posedge core_clk);
    rd_en <= '1;
    addr <= a;
    @(posedge core_clk);
    rd_en <= '0;
    #1 `CHK(rd_valid, 1'b1)
    `CHK(rd_data, e)
  endtask
  task alu(input [2:0] op, input [7:0] b);
    @(posedge core_clk);
    alu_en <= '1;
    alu_op <= op;
    alu_b <= b;
    @(posedge core_clk);
    alu_en <= '0;
    cyc(2);
    #1;
  endtask
  // one pulse of halt, timeout, clear; flags read once they settle
  task ev(input [2:0] m);
    @(posedge core_clk);
    {halt, wdt_timeout, wdt_clear} <= m;
    @(posedge core_clk);
    {halt, wdt_timeout, wdt_clear} <= 3'h0;
    cyc(1);
    #1;
  endtask
  task t_regs;
    wr(`A_PTR0, 8'h40);
    wr(`A_IND0, 8'h11);
    wr(`A_BANK, 8'h01);
    wr(`A_PTR1, 8'h40);
    wr(`A_IND1, 8'h22);
    rd(`A_PTR1, 8'h40);
    rd(`A_IND1, 8'h22);
    rd(`A_IND0, 8'h11);
    rd(8'h40, 8'h11);
    wr(`A_PTR0, `A_IND1);
    wr(`A_IND0, 8'h77);
    rd(`A_IND0, 8'h00);
    rd(`A_PTR0, `A_IND1);
    wr(`A_BANK, 8'h00);
    rd(`A_IND1, 8'h11);
    wr(8'hff, 8'h3c);
    rd(8'hff, 8'h3c);
    rd(8'h3c, 8'h00);
    $display("regs test done");
  endtask
  task t_reset;
    wr(`A_BANK, 8'h01);
    @(posedge core_clk);
    rst <= '1;
    wdt_reset_asleep <= '1;
    cyc(2);
    rst <= '0;
    wdt_reset_asleep <= '0;
    rd(`A_BANK, 8'h01);
    @(posedge core_clk);
    rst <= '1;
    cyc(2);
    rst <= '0;
    rd(`A_BANK, 8'h00);
    $display("reset test done");
  endtask
  task t_jump;
    wr(`A_PCLO, 8'h5a);
    #1 `CHK(pc_low, 8'h5a)
    `CHK(pc_load, 1'b1)
    @(posedge core_clk);
    #1 `CHK(stall, 1'b1)
    $display("jump test done");
  endtask
  task t_table;
    wr(`A_TABLE_POINTER, 8'h33);
    #1 `CHK(table_addr, 8'h33)
    @(posedge core_clk);
    table_rd <= '1;
    @(posedge core_clk);
    table_rd <= '0;
    rd(`A_TABLE_HIGH_BYTE, 8'hcc);
    $display("table test done");
  endtask
  task t_alu;
    @(posedge core_clk);
    work_load <= '1;
    wr_data <= 8'h7f;
    @(posedge core_clk);
    work_load <= '0;
    alu(`OP_ADD, 8'h01);
    `CHK(work_out, 8'h80)
    `CHK(status_out[3:0], 4'ha)
    alu(`OP_SUB, 8'h80);
    `CHK(status_out[3:0], 4'h7)
    alu(`OP_RLC, 8'h00);
    `CHK(work_out, 8'h01)
    `CHK(status_out[`ST_C], 1'b0)
    alu(`OP_LOGIC, 8'h00);
    `CHK(work_out, 8'h00)
    `CHK(status_out[3:0], 4'h6)
    wr(`A_STAT, 8'hff);
    cyc(1);
    #1 `CHK(status_out, 8'h0f)
    alu(`OP_RRC, 8'h00);
    `CHK(work_out, 8'h80)
    `CHK(status_out[3:0], 4'ha)
    $display("alu test done");
  endtask
  task t_sys;
    ev(3'h4);
    `CHK(status_out[5:4], 2'h1)
    ev(3'h2);
    `CHK(status_out[5:4], 2'h3)
    ev(3'h4);
    `CHK(status_out[5:4], 2'h1)
    ev(3'h1);
    `CHK(status_out[5:4], 2'h0)
    $display("system flag test done");
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end
  initial begin
    cyc(4);
    rst <= '0;
    power_up <= '0;
    t_regs;
    t_reset;
    t_jump;
    t_table;
    t_alu;
    t_sys;
    end_of_test;
  end
endmodule // sfr_indirect_bank_status_tb
